// ==== rtl/tots_params.svh ====
`ifndef TOTS_PARAMS_SVH
`define TOTS_PARAMS_SVH
// register byte addresses
`define TOTS_A_CTRL 8'h00
`define TOTS_A_TDLY 8'h04
`define TOTS_A_RDLY 8'h08
`define TOTS_A_DUR 8'h0c
`define TOTS_A_STAT 8'h10
// control field positions
`define TOTS_B_RUN 0
`define TOTS_B_JOBCHG 7
`define TOTS_CTRL_W 7
// reset values
`define TOTS_CTRL_RST 7'h00
`define TOTS_DLY_RST 12'h000
// limits and timing
`define TOTS_DLY_MAX 12'hbb8
`define TOTS_QDEPTH 5'h14
`define TOTS_CLK_NS 5
`define TOTS_MS_NS 1000000
`endif

// ==== rtl/tots_pkg.sv ====
package tots_pkg;
    typedef enum logic [1:0] {RD_NONE = 2'h0, RD_ALL = 2'h1, RD_EJ = 2'h2} tots_rdmode_t;
    typedef struct packed {
        logic dur_en;
        tots_rdmode_t rd;
        logic cot;
        logic enc;
        logic sink;
        logic run;
    } tots_cfg_t;
    typedef struct packed {
        logic eject;
        logic [7:0] res;
    } tots_res_t;
    typedef struct packed {
        logic [15:0] stamp;
        logic done;
        logic net;
        tots_res_t r;
    } tots_ent_t;
    typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_TDLY = 3'h2, ST_EVAL = 3'h4} tots_st_t;
endpackage : tots_pkg

// ==== rtl/tots_seq.sv ====
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`include "tots_params.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - an accepted trigger edge drops ready and valid
// - without delays, results load and ready and valid rise together
// - valid means outputs hold results; ready means next trigger accepted
// - sinking polarity inverts the ready, valid, result and ejector levels (not capture), sequences unchanged
// - trigger delay applies to the hardware trigger only
// - with trigger delay, capture waits for it to elapse
// - change on trigger clears result outputs at the trigger
// - ejector-only delay: ejector untouched at trigger, set after delay
// - result delay counts from the trigger edge; for a network trigger, from the end of processing
// - delay on all outputs: ready rises as soon as evaluation ends
// - delay on all outputs: outputs and valid update after the delay
// - result duration returns each set output to inactive, a pulse
// - delays count milliseconds or encoder steps as configured
// - trigger and result delays limited to 3000 units
// - at most 20 pending parts; job change or leaving run clears them
// - change on result holds outputs until the next valid result
////////////////////////////////////////////////////////////////////////////////

module tots_dtimer (
    // clock
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic clr,
    input wire logic load,
    input wire logic tick,
    input wire logic [11:0] dur,
    // expiry
    output logic expire
);
    logic [11:0] cnt_q;

    assign expire = ce && tick && !clr && !load && (cnt_q == 12'h001);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 12'h000;
        else if (ce)
        begin
            if (clr)
                cnt_q <= 12'h000;
            else if (load)
                cnt_q <= dur;
            else if (tick && cnt_q != 12'h000)
                cnt_q <= cnt_q - 12'h001;
        end
    end
endmodule : tots_dtimer

////////////////////////////////////////////////////////////////////////////////

module tots_seq #(
    parameter int unsigned MS_CYCLES = `TOTS_MS_NS / `TOTS_CLK_NS
) (
    // clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // trigger side
    input wire logic trig_i,
    input wire logic net_trig_i,
    input wire logic enc_step_i,
    // evaluation engine
    output logic capture_o,
    input wire logic eval_done_i,
    input wire tots_pkg::tots_res_t eval_res_i,
    // output pins
    output logic ready_o,
    output logic valid_o,
    output logic [7:0] res_o,
    output logic eject_o
);
    function automatic logic [4:0] nxt_ptr(input logic [4:0] p);
        nxt_ptr = (p == `TOTS_QDEPTH - 5'h01) ? 5'h00 : p + 5'h01;
    endfunction : nxt_ptr

    function automatic logic [11:0] dly_wr(input logic [11:0] old, input logic [11:0] wd,
                                           input logic [1:0] be);
        logic [11:0] m;
        m = {be[1] ? wd[11:8] : old[11:8], be[0] ? wd[7:0] : old[7:0]};
        dly_wr = (m > `TOTS_DLY_MAX) ? `TOTS_DLY_MAX : m;
    endfunction : dly_wr

    tots_pkg::tots_cfg_t cfg_q;
    tots_pkg::tots_st_t st_q, st_d;
    tots_pkg::tots_ent_t q_q [`TOTS_QDEPTH];
    logic [11:0] tdly_q, rdly_q, dur_q, tcnt_q;
    logic [17:0] ms_cnt_q;
    logic [15:0] tnow_q;
    logic [4:0] wr_q, rd_q, cur_q, cnt_q;
    logic [7:0] res_q;
    logic [10:0] pins_q;
    logic ack_q, trig_q, pend_q, ej_q, valid_q, capture_q;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // register bus: one wait cycle per access, so reads always come from a flop

    wire logic req = avs_read || avs_write;
    wire logic wr_en = ce && avs_write && ack_q;
    wire logic ctrl_wr = wr_en && avs_address == `TOTS_A_CTRL && avs_byteenable[0];
    wire logic stop = ctrl_wr && (avs_writedata[`TOTS_B_JOBCHG]
                      || (cfg_q.run && !avs_writedata[`TOTS_B_RUN]));
    wire logic full = cnt_q == `TOTS_QDEPTH;
    wire logic ready_l = st_q == tots_pkg::ST_IDLE && cfg_q.run && !full;

    assign avs_waitrequest = req && !ack_q;
    assign rd_mux = (avs_address == `TOTS_A_CTRL) ? {25'h0, cfg_q} :
                    (avs_address == `TOTS_A_TDLY) ? {20'h0, tdly_q} :
                    (avs_address == `TOTS_A_RDLY) ? {20'h0, rdly_q} :
                    (avs_address == `TOTS_A_DUR) ? {20'h0, dur_q} :
                    (avs_address == `TOTS_A_STAT) ?
                        {21'h0, pend_q, cnt_q, st_q, valid_q, ready_l} : 32'h0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0;
            cfg_q <= tots_pkg::tots_cfg_t'(`TOTS_CTRL_RST);
            tdly_q <= `TOTS_DLY_RST;
            rdly_q <= `TOTS_DLY_RST;
            dur_q <= `TOTS_DLY_RST;
        end
        else if (ce)
        begin
            ack_q <= req && !ack_q;
            if (avs_read && !ack_q)
                avs_readdata <= rd_mux;
            if (ctrl_wr)
                cfg_q <= tots_pkg::tots_cfg_t'(avs_writedata[`TOTS_CTRL_W-1:0]);
            if (wr_en && avs_address == `TOTS_A_TDLY)
                tdly_q <= dly_wr(tdly_q, avs_writedata[11:0], avs_byteenable[1:0]);
            if (wr_en && avs_address == `TOTS_A_RDLY)
                rdly_q <= dly_wr(rdly_q, avs_writedata[11:0], avs_byteenable[1:0]);
            if (wr_en && avs_address == `TOTS_A_DUR)
                dur_q <= dly_wr(dur_q, avs_writedata[11:0], avs_byteenable[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timebase: millisecond prescaler or encoder step

    wire logic ms_tick = ms_cnt_q == 18'(MS_CYCLES - 1);
    wire logic tick = cfg_q.enc ? enc_step_i : ms_tick;

    ////////////////////////////////////////////////////////////////////////////
    // trigger sequencer

    wire logic hw_edge = trig_i && !trig_q;
    wire logic accept = ce && ready_l && (hw_edge || net_trig_i) && !stop;
    wire logic use_q = cfg_q.rd == tots_pkg::RD_ALL || cfg_q.rd == tots_pkg::RD_EJ;
    wire logic done = ce && st_q == tots_pkg::ST_EVAL && eval_done_i && !stop;
    wire logic push = accept && use_q;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            tots_pkg::ST_IDLE:
                if (accept)
                    st_d = (hw_edge && tdly_q != 12'h000) ? tots_pkg::ST_TDLY
                                                          : tots_pkg::ST_EVAL;
            tots_pkg::ST_TDLY:
                if (tick && tcnt_q + 12'h001 >= tdly_q)
                    st_d = tots_pkg::ST_EVAL;
            tots_pkg::ST_EVAL:
                if (eval_done_i)
                    st_d = tots_pkg::ST_IDLE;
            default:
                st_d = tots_pkg::ST_IDLE;
        endcase
        if (stop)
            st_d = tots_pkg::ST_IDLE;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= tots_pkg::ST_IDLE;
            trig_q <= 1'b0;
            tcnt_q <= 12'h000;
            capture_q <= 1'b0;
            ms_cnt_q <= 18'h0;
            tnow_q <= 16'h0;
        end
        else if (ce)
        begin
            st_q <= st_d;
            trig_q <= trig_i;
            // capture pulses once, on entry to evaluation
            capture_q <= st_d == tots_pkg::ST_EVAL && st_q != tots_pkg::ST_EVAL;
            tcnt_q <= (st_q == tots_pkg::ST_TDLY && tick) ? tcnt_q + 12'h001 :
                      (st_q == tots_pkg::ST_TDLY) ? tcnt_q : 12'h000;
            ms_cnt_q <= ms_tick ? 18'h0 : ms_cnt_q + 18'h1;
            tnow_q <= tick ? tnow_q + 16'h1 : tnow_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending-part queue; the 16-bit stamp outlives the 3000-unit limit

    wire logic [15:0] q_age = tnow_q - q_q[rd_q].stamp;
    wire logic pop = ce && !stop && cnt_q != 5'h00 && q_q[rd_q].done
                     && q_age >= {4'h0, rdly_q};
    wire tots_pkg::tots_res_t q_head = q_q[rd_q].r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_q <= '{default: '0};
            wr_q <= 5'h00;
            rd_q <= 5'h00;
            cur_q <= 5'h00;
            cnt_q <= 5'h00;
            pend_q <= 1'b0;
        end
        else if (stop)
        begin
            wr_q <= 5'h00;
            rd_q <= 5'h00;
            cnt_q <= 5'h00;
            pend_q <= 1'b0;
        end
        else if (ce)
        begin
            if (push)
            begin
                q_q[wr_q] <= '{stamp: tnow_q, done: 1'b0, net: !hw_edge, r: '0};
                cur_q <= wr_q;
                wr_q <= nxt_ptr(wr_q);
                pend_q <= 1'b1;
            end
            if (done && pend_q)
            begin
                q_q[cur_q].done <= 1'b1;
                q_q[cur_q].r <= eval_res_i;
                // a network trigger starts its delay after processing
                if (q_q[cur_q].net)
                    q_q[cur_q].stamp <= tnow_q;
                pend_q <= 1'b0;
            end
            if (pop)
                rd_q <= nxt_ptr(rd_q);
            if (push && !pop)
                cnt_q <= cnt_q + 5'h01;
            else if (pop && !push)
                cnt_q <= cnt_q - 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result outputs, logical levels

    wire logic m_none = !use_q;
    wire logic m_all = cfg_q.rd == tots_pkg::RD_ALL;
    wire logic m_ej = cfg_q.rd == tots_pkg::RD_EJ;
    wire logic res_ld = (done && !m_all) || (pop && m_all);
    wire tots_pkg::tots_res_t res_src = m_all ? q_head : eval_res_i;
    wire logic ej_ld = (done && m_none) || (pop && !m_none);
    wire tots_pkg::tots_res_t ej_src = m_none ? eval_res_i : q_head;
    wire logic cot_clr = accept && cfg_q.cot;
    wire logic res_exp, ej_exp;

    tots_dtimer u_res_dur (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clr(stop),
        .load(res_ld && cfg_q.dur_en),
        .tick(tick),
        .dur(dur_q),
        .expire(res_exp)
    );

    tots_dtimer u_ej_dur (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clr(stop),
        .load(ej_ld && cfg_q.dur_en),
        .tick(tick),
        .dur(dur_q),
        .expire(ej_exp)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            res_q <= 8'h00;
            ej_q <= 1'b0;
            valid_q <= 1'b0;
            pins_q <= 11'h000;
        end
        else if (ce)
        begin
            // for res_q and ej_q, a new result wins over a trigger or duration clear in the same cycle, but not over stop
            if (stop)
                res_q <= 8'h00;
            else if (res_ld)
                res_q <= res_src.res;
            else if (cot_clr || res_exp)
                res_q <= 8'h00;
            if (stop)
                ej_q <= 1'b0;
            else if (ej_ld)
                ej_q <= ej_src.eject;
            else if ((cot_clr && !m_ej) || ej_exp)
                ej_q <= 1'b0;
            if (stop || accept)
                valid_q <= 1'b0;
            else if ((done && !m_all) || (pop && m_all))
                valid_q <= 1'b1;
            pins_q <= {ready_l, valid_q, ej_q, res_q} ^ {11{cfg_q.sink}};
        end
    end

    assign ready_o = pins_q[10];
    assign valid_o = pins_q[9];
    assign eject_o = pins_q[8];
    assign res_o = pins_q[7:0];
    assign capture_o = capture_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_trig;
        accept |=> !ready_l && !valid_q && st_q != tots_pkg::ST_IDLE;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not drop ready/valid");
    property p_busy;
        ce && st_q == tots_pkg::ST_EVAL && !eval_done_i && !stop && hw_edge
            |=> st_q == tots_pkg::ST_EVAL && !capture_q;
    endproperty
    a_busy: assert property (p_busy) else $error("trigger taken while busy");
    property p_none;
        done && m_none |=> valid_q && ready_l && res_q == $past(eval_res_i.res);
    endproperty
    a_none: assert property (p_none) else $error("no-delay result not set");
    property p_pol;
        $past(ce) && cfg_q.sink && $past(cfg_q.sink) |-> valid_o == !$past(valid_q);
    endproperty
    a_pol: assert property (p_pol) else $error("sinking level not inverted");
    property p_net;
        accept && !hw_edge |=> st_q == tots_pkg::ST_EVAL && capture_o;
    endproperty
    a_net: assert property (p_net) else $error("network trigger was delayed");
    property p_tdly;
        accept && hw_edge && tdly_q != 12'h000 |=> st_q == tots_pkg::ST_TDLY && !capture_o;
    endproperty
    a_tdly: assert property (p_tdly) else $error("capture before trigger delay");
    property p_cot;
        accept && cfg_q.cot && !m_ej && !pop |=> res_q == 8'h00 && !ej_q;
    endproperty
    a_cot: assert property (p_cot) else $error("outputs not cleared on trigger");
    property p_ej;
        accept && m_ej && !pop && !ej_exp |=> $stable(ej_q);
    endproperty
    a_ej: assert property (p_ej) else $error("ejector touched at trigger");
    property p_all_rdy;
        done && m_all |=> st_q == tots_pkg::ST_IDLE;
    endproperty
    a_all_rdy: assert property (p_all_rdy) else $error("ready waited for delay");
    property p_all_val;
        ce && m_all && !valid_q ##1 valid_q |-> $past(pop) && $past(q_age) >= $past(rdly_q);
    endproperty
    a_all_val: assert property (p_all_val) else $error("valid before delay");
    property p_dur;
        res_exp && !res_ld && !stop |=> res_q == 8'h00;
    endproperty
    a_dur: assert property (p_dur) else $error("result pulse did not end");
    property p_lim;
        tdly_q <= `TOTS_DLY_MAX && rdly_q <= `TOTS_DLY_MAX;
    endproperty
    a_lim: assert property (p_lim) else $error("delay above limit");
    property p_clr;
        (cnt_q <= `TOTS_QDEPTH) and (stop |=> cnt_q == 5'h00 && !valid_q);
    endproperty
    a_clr: assert property (p_clr) else $error("part buffer overrun or not cleared");
    property p_hold;
        ce && m_none && !cfg_q.cot && !cfg_q.dur_en && !done && !stop |=> $stable(res_q);
    endproperty
    a_hold: assert property (p_hold) else $error("output changed without result");

    c_cycle: cover property (accept ##[1:200] done);
    c_queue: cover property (pop && cnt_q > 5'h01);
    c_pulse: cover property (res_exp ##1 res_q == 8'h00);
endmodule : tots_seq

// ==== testbench/tots_ctrl_model.sv ====
`timescale 1ns/100ps

module tots_ctrl_model (
    // clock
    input wire logic clk,
    input wire logic rst_n,
    // from sequencer
    input wire logic capture_o,
    // to sequencer
    output logic trig_i,
    output logic net_trig_i,
    output logic eval_done_i,
    output tots_pkg::tots_res_t eval_res_i
);
    int lat = 10;
    int cnt = 0;
    int n_cap = 0;
    time t_trig = 0;
    tots_pkg::tots_res_t res_next = '0;

    initial
    begin
        trig_i = 1'b0;
        net_trig_i = 1'b0;
        eval_done_i = 1'b0;
        eval_res_i = '0;
    end

    // evaluation engine; result lines churn outside the done pulse
    always @(posedge clk)
    begin
        eval_done_i <= 1'b0;
        eval_res_i <= ~eval_res_i;
        if (!rst_n)
            cnt <= 0;
        else if (capture_o === 1'b1)
        begin
            n_cap <= n_cap + 1;
            cnt <= lat;
        end
        else if (cnt == 1)
        begin
            eval_done_i <= 1'b1;
            eval_res_i <= res_next;
            cnt <= 0;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end

    // one-cycle trigger pulses; the tasks do not wait for ready, so a trigger can land while busy
    task automatic hw_trig;
    begin
        @(posedge clk);
        trig_i <= 1'b1;
        t_trig = $time;
        @(posedge clk);
        trig_i <= 1'b0;
    end
    endtask : hw_trig

    task automatic net_trig;
    begin
        @(posedge clk);
        net_trig_i <= 1'b1;
        t_trig = $time;
        @(posedge clk);
        net_trig_i <= 1'b0;
    end
    endtask : net_trig
endmodule : tots_ctrl_model

// ==== testbench/tots_seq_test.sv ====
`timescale 1ns/100ps
`include "tots_params.svh"

module tots_seq_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic trig_i, net_trig_i, eval_done_i, enc_step_i = 1'b0;
    logic capture_o, ready_o, valid_o, eject_o;
    logic [7:0] res_o;
    tots_pkg::tots_res_t eval_res_i;
    int cyc = 0;
    int bad_count = 0;
    int n_compared = 0;
    int dt, d2, n0;
    logic [31:0] rd;

    // short millisecond so delays stay cheap in simulation
    tots_seq #(.MS_CYCLES(10)) tots_seq_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trig_i(trig_i), .net_trig_i(net_trig_i),
        .enc_step_i(enc_step_i), .capture_o(capture_o), .eval_done_i(eval_done_i),
        .eval_res_i(eval_res_i), .ready_o(ready_o), .valid_o(valid_o), .res_o(res_o),
        .eject_o(eject_o));
    tots_ctrl_model tots_ctrl_model_inst (.clk(clk), .rst_n(rst_n), .capture_o(capture_o),
        .trig_i(trig_i), .net_trig_i(net_trig_i), .eval_done_i(eval_done_i),
        .eval_res_i(eval_res_i));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // encoder step every fourth cycle
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        enc_step_i <= (cyc % 4 == 0);
    end

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask : chk

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        // the write lands at the edge where waitrequest is seen low
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    end
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    begin
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    end
    endtask : bus_rd

    function automatic logic pin(input int s);
        case (s)
            0: return ready_o;
            1: return valid_o;
            2: return eject_o;
            default: return capture_o;
        endcase
    endfunction : pin

    // bounded wait on a pin; d is cycles since the last trigger
    task automatic wait_for(input int sel, input logic lvl, output int d);
        int n;
    begin
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (pin(sel) !== lvl && n < 600);
        chk(32'(n < 600), 32'h1);
        d = int'(($time - tots_ctrl_model_inst.t_trig) / 5);
    end
    endtask : wait_for

    task automatic run_one(input logic [8:0] r, input int lat);
    begin
        tots_ctrl_model_inst.res_next = r;
        tots_ctrl_model_inst.lat = lat;
        tots_ctrl_model_inst.hw_trig();
        wait_for(3, 1'b1, dt);
        // pins follow the capture pulse by one cycle
        @(negedge clk);
    end
    endtask : run_one

    ////////////////////////////////////////////////////////////
    task automatic s_regs;
    begin
        bus_rd(`TOTS_A_CTRL, rd);
        chk(rd, 32'h0);
        bus_rd(`TOTS_A_STAT, rd);
        chk(rd, 32'h4);
        bus_wr(`TOTS_A_TDLY, 32'hfff);
        bus_wr(`TOTS_A_RDLY, 32'hbb9);
        bus_wr(8'h20, 32'h123);
        bus_rd(8'h20, rd);
        chk(rd, 32'h0);
        bus_rd(`TOTS_A_TDLY, rd);
        chk(rd, 32'hbb8);
        bus_rd(`TOTS_A_RDLY, rd);
        chk(rd, 32'hbb8);
        bus_wr(`TOTS_A_TDLY, 32'h0);
        bus_wr(`TOTS_A_RDLY, 32'h0);
        $display("test regs done");
    end
    endtask : s_regs

    task automatic s_plain;
    begin
        bus_wr(`TOTS_A_CTRL, 32'h1);
        wait_for(0, 1'b1, dt);
        n0 = tots_ctrl_model_inst.n_cap;
        run_one(9'h0a5, 20);
        chk(32'(dt inside {[1:4]}), 32'h1);
        chk(32'({ready_o, valid_o}), 32'h0);
        tots_ctrl_model_inst.hw_trig();
        wait_for(1, 1'b1, dt);
        chk(32'(ready_o), 32'h1);
        chk(32'({res_o, eject_o}), 32'h14a);
        chk(32'(tots_ctrl_model_inst.n_cap - n0), 32'h1);
        run_one(9'h03c, 20);
        chk(32'(res_o), 32'ha5);
        wait_for(1, 1'b1, dt);
        chk(32'(res_o), 32'h3c);
        $display("test plain done");
    end
    endtask : s_plain

    task automatic s_sink;
    begin
        bus_wr(`TOTS_A_CTRL, 32'h3);
        wait_for(0, 1'b0, dt);
        run_one(9'h00f, 10);
        chk(32'({ready_o, valid_o}), 32'h3);
        wait_for(1, 1'b0, dt);
        chk(32'({res_o, eject_o, ready_o}), 32'h3c2);
        $display("test sink done");
    end
    endtask : s_sink

    task automatic s_tdly;
    begin
        bus_wr(`TOTS_A_CTRL, 32'h1);
        bus_wr(`TOTS_A_TDLY, 32'h3);
        wait_for(0, 1'b1, dt);
        run_one(9'h011, 10);
        chk(32'(dt inside {[20:42]}), 32'h1);
        wait_for(1, 1'b1, dt);
        tots_ctrl_model_inst.net_trig();
        wait_for(3, 1'b1, dt);
        chk(32'(dt inside {[1:4]}), 32'h1);
        wait_for(1, 1'b1, dt);
        bus_wr(`TOTS_A_TDLY, 32'h0);
        $display("test trigger delay done");
    end
    endtask : s_tdly

    task automatic s_cot;
    begin
        bus_wr(`TOTS_A_CTRL, 32'h9);
        run_one(9'h1ff, 20);
        wait_for(1, 1'b1, dt);
        chk(32'({res_o, eject_o}), 32'h1ff);
        run_one(9'h003, 20);
        chk(32'({res_o, eject_o}), 32'h0);
        wait_for(1, 1'b1, dt);
        chk(32'(res_o), 32'h03);
        $display("test change on trigger done");
    end
    endtask : s_cot

    task automatic s_rall;
    begin
        bus_wr(`TOTS_A_CTRL, 32'h11);
        bus_wr(`TOTS_A_RDLY, 32'h8);
        run_one(9'h066, 20);
        wait_for(0, 1'b1, dt);
        chk(32'(dt inside {[20:34]}), 32'h1);
        chk(32'(valid_o), 32'h0);
        wait_for(1, 1'b1, dt);
        chk(32'(dt inside {[70:95]}), 32'h1);
        chk(32'({res_o, eject_o}), 32'hcc);
        $display("test result delay all done");
    end
    endtask : s_rall

    // encoder timebase, ejector delayed 12 steps, pulses 3 steps long
    task automatic s_rej;
    begin
        bus_wr(`TOTS_A_CTRL, 32'h65);
        bus_wr(`TOTS_A_RDLY, 32'hc);
        bus_wr(`TOTS_A_DUR, 32'h3);
        run_one(9'h15a, 10);
        wait_for(1, 1'b1, dt);
        chk(32'({res_o, eject_o}), 32'hb4);
        wait_for(2, 1'b1, dt);
        chk(32'(dt inside {[44:60]}), 32'h1);
        wait_for(2, 1'b0, d2);
        chk(32'((d2 - dt) inside {[8:16]}), 32'h1);
        chk(32'(res_o), 32'h0);
        run_one(9'h100, 10);
        wait_for(1, 1'b1, dt);
        bus_wr(`TOTS_A_CTRL, 32'he5);
        bus_rd(`TOTS_A_STAT, rd);
        chk(32'(rd[9:5]), 32'h0);
        // the dropped part would have fired the ejector inside this span
        n0 = 0;
        repeat (60)
        begin
            @(negedge clk);
            if (eject_o !== 1'b0)
                n0++;
        end
        chk(32'(n0), 32'h0);
        $display("test ejector delay done");
    end
    endtask : s_rej

    ////////////////////////////////////////////////////////////
    task end_sim;
    begin
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask : end_sim

    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        s_regs();
        s_plain();
        s_sink();
        s_tdly();
        s_cot();
        s_rall();
        s_rej();
        end_sim();
    end

    // whole run needs well under 3000 cycles
    initial
    begin
        repeat (10000) @(posedge clk);
        bad_count++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : tots_seq_test
